// file: rtl/mmio_pkg.sv
// Purpose: Constants and carrier types for the multi-mode I/O port block.
// Assumes: 8-bit register bus, one 10 MHz clock.
// Notes: Offsets chosen for direction and select registers are listed in the handover.
package mmio_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_DATA_STD = 8'h00; // Standard port data latch
    localparam logic [7:0] OFF_DATA_OD = 8'h05; // Open-drain port data latch
    localparam logic [7:0] OFF_DATA_CMP = 8'h07; // Compare-output port data
    localparam logic [7:0] OFF_DIR_STD = 8'h10; // Standard direction
    localparam logic [7:0] OFF_DIR_CMP = 8'h17; // Compare port direction
    localparam logic [7:0] OFF_SEL_STD = 8'h20; // Upper nibble: peripheral select
    localparam logic [7:0] OFF_SEL_OD = 8'h25; // Open-drain peripheral select
    localparam logic [7:0] OFF_SEL_CMP = 8'h27; // Compare output select
    localparam logic [7:0] OFF_BUS_SEL = 8'h28; // Port-3-like bus signal select
    localparam logic [7:0] OFF_CMP_LVL = 8'h30; // Compare output level bits
    localparam logic [7:0] OFF_STATUS = 8'h38; // Mode status
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONES = 8'hFF;
    localparam int SEL_LOW = 4; // First peripheral-selectable bit

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } mmio_pin_drv_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mmio_bus_req_t;

    typedef enum logic [1:0] {
        MMIO_RD_IDLE = 2'b00,
        MMIO_RD_DONE = 2'b01
    } mmio_rd_state_t;
endpackage

// file: rtl/mmio_port.sv
// Purpose: One standard, one open-drain and one compare-output 8-bit port.
// Assumes: Pin inputs synchronous to ref_clk; external bus logic supplies busOut/busOe.
// Notes: Reads answer one cycle after the read strobe; no wait states.
//
// Summary of operation
// - Standard port is GPIO in single-chip mode; in bus mode, pins go to the bus unless bus-selected.
// - In bus mode, bus-select bits return chosen standard pins to GPIO.
// - Upper four standard bits each selectable to peripheral or port.
// - Standard pin is output when its direction bit is 1.
// - Output pin: a data write stores and drives the value.
// - Output pin read returns the latch value seen on the pin.
// - Read-modify-write writes sampled input levels back into input latches.
// - Direction 0 disables the output buffer, pin high impedance.
// - Input pin: data writes are stored, pin unaffected.
// - Input pin read returns the present pin level.
// - Each open-drain pin selectable between peripheral and port.
// - Open-drain latch 0 drives low; latch 1 releases the pin.
// - Open-drain read while outputting returns the pin, matching the latch.
// - Open-drain read-modify-write uses latch contents, not pin levels.
// - Compare port never drives software-written latch data.
// - Compare select register is stored and read back but does not change compare pin ownership.
// - Compare direction 1 enables buffer, drives compare unit's latch.
// - Compare level writes reach the pin only at the next match.
// - Compare port read returns the pin level, i.e. compare output when enabled.
// - Compare direction 0 turns the buffer off, pin high impedance.
// - Each port data latch is one byte in low I/O space, bit n to pin n.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module mmio_port #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    // Register bus
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic rmwStb,
    output logic [7:0] rdata,
    // Mode and peripheral hand-over
    input wire logic extBusMode,
    input wire logic [7:0] busOut,
    input wire logic [7:0] busOe,
    input wire logic [7:0] periStdOut,
    input wire logic [7:0] periStdOe,
    input wire logic [7:0] periOdOut,
    input wire logic [7:0] cmpMatch,
    // Pins
    input wire logic [7:0] stdPinIn,
    output logic [7:0] stdPinOut,
    output logic [7:0] stdPinOe,
    input wire logic [7:0] odPinIn,
    output logic [7:0] odPinOut,
    output logic [7:0] odPinOe,
    input wire logic [7:0] cmpPinIn,
    output logic [7:0] cmpPinOut,
    output logic [7:0] cmpPinOe
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (WIDTH != 8)
    begin : g_bad_width
        $error("mmio_port supports byte-wide ports only");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] stdLatch_reg;
    logic [7:0] odLatch_reg;
    logic [7:0] stdDir_reg;
    logic [7:0] cmpDir_reg;
    logic [7:0] stdSel_reg;
    logic [7:0] odSel_reg;
    logic [7:0] cmpSel_reg;
    logic [7:0] busSel_reg;
    logic [7:0] cmpLvl_reg;
    logic [7:0] cmpOut_reg;
    logic [7:0] stdGpio;
    logic [7:0] stdOut_next;
    logic [7:0] stdOe_next;
    logic [7:0] odOut_next;
    logic [7:0] odOe_next;
    logic [7:0] cmpOe_next;
    logic [7:0] rdata_next;
    logic [7:0] stdRd;
    logic [7:0] stdWr_next;
    logic stdWr;
    logic odWr;
    mmio_pkg::mmio_rd_state_t rdState_reg;

    assign stdWr = wrStb && (addr == mmio_pkg::OFF_DATA_STD);
    assign odWr = wrStb && (addr == mmio_pkg::OFF_DATA_OD);

    // ------------------------------------------------------------
    // Pin ownership for the standard port
    // ------------------------------------------------------------
    // A pin is plain GPIO in single-chip mode, or in bus mode when bus-select claims it
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            stdGpio[i] = !extBusMode || busSel_reg[i];
        end
    end

    // Read view: outputs read latch (same as pin), inputs read the pin
    assign stdRd = (stdDir_reg & stdLatch_reg) | (~stdDir_reg & stdPinIn);

    // Read-modify-write stores the full byte, so inputs get their pin levels
    assign stdWr_next = rmwStb ? ((wdata & stdDir_reg) | (stdRd & ~stdDir_reg))
                               : wdata;

    // ------------------------------------------------------------
    // Data latches
    // ------------------------------------------------------------
    // Latch always stores; pins follow only where the bit drives
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stdLatch_reg <= mmio_pkg::RST_ZERO;
        end
        else if (stdWr)
        begin
            stdLatch_reg <= stdWr_next;
        end
    end

    // Input bits keep plain writes; output bits keep the written bit on RMW
    a_std_write_input: assert property (@(posedge ref_clk) disable iff (rst)
        (stdWr && !rmwStb && !stdDir_reg[2]) |=> stdLatch_reg[2] == $past(wdata[2]))
        else $error("input latch write lost");
    a_std_rmw_output: assert property (@(posedge ref_clk) disable iff (rst)
        (stdWr && rmwStb && stdDir_reg[0]) |=> stdLatch_reg[0] == $past(wdata[0]))
        else $error("rmw changed output bit");

    // Open-drain latch resets released; RMW operand is the latch itself
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            odLatch_reg <= mmio_pkg::RST_ONES;
        end
        else if (odWr)
        begin
            odLatch_reg <= wdata;
        end
    end

    // Modify-write here stores the byte as given, never the pin levels
    a_od_rmw_latch: assert property (@(posedge ref_clk) disable iff (rst)
        (odWr && rmwStb) |=> odLatch_reg == $past(wdata))
        else $error("open drain rmw took pin levels");

    // ------------------------------------------------------------
    // Direction and selection registers
    // ------------------------------------------------------------
    // One register per address; unmapped writes fall through untouched
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stdDir_reg <= mmio_pkg::RST_ZERO;
            cmpDir_reg <= mmio_pkg::RST_ZERO;
            stdSel_reg <= mmio_pkg::RST_ZERO;
            odSel_reg <= mmio_pkg::RST_ZERO;
            cmpSel_reg <= mmio_pkg::RST_ZERO;
            busSel_reg <= mmio_pkg::RST_ZERO;
            cmpLvl_reg <= mmio_pkg::RST_ZERO;
        end
        else if (wrStb)
        begin
            case (addr)
                mmio_pkg::OFF_DIR_STD: stdDir_reg <= wdata;
                mmio_pkg::OFF_DIR_CMP: cmpDir_reg <= wdata;
                // Only the upper nibble can be handed to a peripheral
                mmio_pkg::OFF_SEL_STD:
                    stdSel_reg <= wdata & (mmio_pkg::RST_ONES << mmio_pkg::SEL_LOW);
                mmio_pkg::OFF_SEL_OD: odSel_reg <= wdata;
                mmio_pkg::OFF_SEL_CMP: cmpSel_reg <= wdata;
                mmio_pkg::OFF_BUS_SEL: busSel_reg <= wdata;
                mmio_pkg::OFF_CMP_LVL: cmpLvl_reg <= wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Compare output latches
    // ------------------------------------------------------------
    // Level bits are armed now but only land on a match, per bit
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_cmp
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    cmpOut_reg[g] <= 1'b0;
                end
                else if (cmpMatch[g])
                begin
                    cmpOut_reg[g] <= cmpLvl_reg[g];
                end
            end
        end
    endgenerate

    // A match loads the armed level bit
    a_cmp_match_load: assert property (@(posedge ref_clk) disable iff (rst)
        cmpMatch[3] |=> cmpOut_reg[3] == $past(cmpLvl_reg[3]))
        else $error("compare level not loaded on match");

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Owner per pin: bus, then peripheral, then the port itself
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (!stdGpio[i])
            begin
                stdOut_next[i] = busOut[i];
                stdOe_next[i] = busOe[i];
            end
            else if (stdSel_reg[i])
            begin
                stdOut_next[i] = periStdOut[i];
                stdOe_next[i] = periStdOe[i];
            end
            else
            begin
                stdOut_next[i] = stdLatch_reg[i];
                stdOe_next[i] = stdDir_reg[i];
            end
            // Open drain: only ever pull low, never drive high
            odOut_next[i] = 1'b0;
            odOe_next[i] = odSel_reg[i] ? !periOdOut[i] : !odLatch_reg[i];
            // Compare port carries compare state only, never a software latch
            cmpOe_next[i] = cmpDir_reg[i];
        end
    end

    // Pads see only flop outputs, so decode glitches never reach the board
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stdPinOut <= mmio_pkg::RST_ZERO;
            stdPinOe <= mmio_pkg::RST_ZERO;
            odPinOut <= mmio_pkg::RST_ZERO;
            odPinOe <= mmio_pkg::RST_ZERO;
            cmpPinOut <= mmio_pkg::RST_ZERO;
            cmpPinOe <= mmio_pkg::RST_ZERO;
        end
        else
        begin
            stdPinOut <= stdOut_next;
            stdPinOe <= stdOe_next;
            odPinOut <= odOut_next;
            odPinOe <= odOe_next;
            cmpPinOut <= cmpOut_reg;
            cmpPinOe <= cmpOe_next;
        end
    end

    // Handed-over pins follow their owners one edge later
    a_std_peri_drive: assert property (@(posedge ref_clk) disable iff (rst)
        (stdGpio[5] && stdSel_reg[5])
        |=> (stdPinOut[5] == $past(periStdOut[5]) && stdPinOe[5] == $past(periStdOe[5])))
        else $error("peripheral pin not handed over");
    a_bus_sel_gpio: assert property (@(posedge ref_clk) disable iff (rst)
        (extBusMode && busSel_reg[1])
        |=> (stdPinOe[1] == $past(stdDir_reg[1]) && stdPinOut[1] == $past(stdLatch_reg[1])))
        else $error("bus-selected pin not returned to port");
    a_od_one_release: assert property (@(posedge ref_clk) disable iff (rst)
        (!odSel_reg[3] && odLatch_reg[3]) |=> !odPinOe[3])
        else $error("open drain one not released");
    a_od_peri_drive: assert property (@(posedge ref_clk) disable iff (rst)
        odSel_reg[2] |=> (odPinOe[2] == !$past(periOdOut[2])))
        else $error("open drain peripheral not followed");
    a_cmp_drive_level: assert property (@(posedge ref_clk) disable iff (rst)
        cmpDir_reg[1] |=> (cmpPinOe[1] && cmpPinOut[1] == $past(cmpOut_reg[1])))
        else $error("compare pin not driving compare latch");

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped addresses read as zero
    always_comb
    begin
        case (addr)
            mmio_pkg::OFF_DATA_STD: rdata_next = stdRd;
            mmio_pkg::OFF_DATA_OD: rdata_next = odPinIn;
            // Pin level; with buffer on this is the compare output
            mmio_pkg::OFF_DATA_CMP: rdata_next = cmpPinIn;
            mmio_pkg::OFF_DIR_STD: rdata_next = stdDir_reg;
            mmio_pkg::OFF_DIR_CMP: rdata_next = cmpDir_reg;
            mmio_pkg::OFF_SEL_STD: rdata_next = stdSel_reg;
            mmio_pkg::OFF_SEL_OD: rdata_next = odSel_reg;
            mmio_pkg::OFF_SEL_CMP: rdata_next = cmpSel_reg;
            mmio_pkg::OFF_BUS_SEL: rdata_next = busSel_reg;
            mmio_pkg::OFF_CMP_LVL: rdata_next = cmpLvl_reg;
            mmio_pkg::OFF_STATUS: rdata_next = {7'h00, extBusMode};
            default: rdata_next = mmio_pkg::RST_ZERO;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= mmio_pkg::RST_ZERO;
            rdState_reg <= mmio_pkg::MMIO_RD_IDLE;
        end
        else
        begin
            rdata <= rdStb ? rdata_next : mmio_pkg::RST_ZERO;
            rdState_reg <= rdStb ? mmio_pkg::MMIO_RD_DONE : mmio_pkg::MMIO_RD_IDLE;
        end
    end

    // Read data is zero outside the answer cycle; open-drain and compare ports read the pins, standard outputs read the latch
    a_read_idle_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (rdState_reg == mmio_pkg::MMIO_RD_IDLE) |-> (rdata == mmio_pkg::RST_ZERO))
        else $error("read data outside answer cycle");
    a_std_output_read: assert property (@(posedge ref_clk) disable iff (rst)
        (rdStb && addr == mmio_pkg::OFF_DATA_STD && stdDir_reg[3])
        |=> rdata[3] == $past(stdLatch_reg[3]))
        else $error("output read not latch value");
    a_od_read_pin: assert property (@(posedge ref_clk) disable iff (rst)
        (rdStb && addr == mmio_pkg::OFF_DATA_OD) |=> rdata == $past(odPinIn))
        else $error("open drain read not pin level");
    a_cmp_read_pin: assert property (@(posedge ref_clk) disable iff (rst)
        (rdStb && addr == mmio_pkg::OFF_DATA_CMP) |=> rdata == $past(cmpPinIn))
        else $error("compare read not pin level");

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_std_input_hiz: assert property (@(posedge ref_clk) disable iff (rst)
        (!stdDir_reg[0] && stdGpio[0] && !stdSel_reg[0]) |=> !stdPinOe[0])
        else $error("input standard pin driven");
    a_std_output_drive: assert property (@(posedge ref_clk) disable iff (rst)
        (stdDir_reg[1] && stdGpio[1] && !stdSel_reg[1])
        |=> (stdPinOe[1] && stdPinOut[1] == $past(stdLatch_reg[1])))
        else $error("output pin not showing latch");
    a_bus_owns_pins: assert property (@(posedge ref_clk) disable iff (rst)
        (extBusMode && !busSel_reg[2]) |=> (stdPinOe[2] == $past(busOe[2])))
        else $error("bus pin not handed over");
    a_od_never_high: assert property (@(posedge ref_clk) disable iff (rst)
        odPinOe[3] |-> !odPinOut[3])
        else $error("open drain driving high");
    a_od_low_on_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (!odSel_reg[4] && !odLatch_reg[4]) |=> odPinOe[4])
        else $error("open drain zero not pulled low");
    a_cmp_match_only: assert property (@(posedge ref_clk) disable iff (rst)
        !cmpMatch[5] |=> $stable(cmpOut_reg[5]))
        else $error("compare level moved without match");
    a_cmp_dir_zero: assert property (@(posedge ref_clk) disable iff (rst)
        !cmpDir_reg[6] |=> !cmpPinOe[6])
        else $error("compare input pin driven");
    a_std_rmw_input: assert property (@(posedge ref_clk) disable iff (rst)
        (stdWr && rmwStb && !stdDir_reg[7]) |=> stdLatch_reg[7] == $past(stdPinIn[7]))
        else $error("rmw lost input level");
    a_read_timing: assert property (@(posedge ref_clk) disable iff (rst)
        (rdStb && addr == mmio_pkg::OFF_DATA_STD && !stdDir_reg[0])
        |=> rdata[0] == $past(stdPinIn[0]))
        else $error("input read wrong");
endmodule // mmio_port

// file: tb/mmio_board.sv
// Purpose: Board-side model of the three ports' pins.
// Assumes: Pin drive is registered on ref_clk by the port block.
// Notes: Open-drain lines have a pull-up; other released lines follow board drive.
`timescale 1ns/10ps
module mmio_board (
    input wire logic [7:0] stdOut,
    input wire logic [7:0] stdOe,
    input wire logic [7:0] odOe,
    input wire logic [7:0] cmpOut,
    input wire logic [7:0] cmpOe,
    input wire logic [7:0] extStd,
    input wire logic [7:0] extOdLow,
    input wire logic [7:0] extCmp,
    output logic [7:0] stdPin,
    output logic [7:0] odPin,
    output logic [7:0] cmpPin
);
    // Released bits show the board, never the last driven value
    assign stdPin = (stdOut & stdOe) | (extStd & ~stdOe);
    // Pull-up wins unless the port or the board sinks the line
    assign odPin = ~(odOe | extOdLow);
    assign cmpPin = (cmpOut & cmpOe) | (extCmp & ~cmpOe);
endmodule // mmio_board

// file: tb/test_multi_mode_io_port_logic.sv
// Purpose: Self-checking bench for the multi-mode I/O port block.
// Assumes: Single 10 MHz clock, reads answer one cycle after the strobe.
// Notes: Pins checked two edges after a write, as the port registers its drive.
`timescale 1ns/10ps
module test_multi_mode_io_port_logic;
    logic ref_clk, rst, wrStb, rdStb, rmwStb, extBusMode;
    logic [7:0] addr, wdata, rdata, busOut, busOe, periStdOut, periStdOe, periOdOut;
    logic [7:0] cmpMatch, stdPinIn, stdPinOut, stdPinOe, odPinIn, odPinOut, odPinOe;
    logic [7:0] cmpPinIn, cmpPinOut, cmpPinOe, extStd, extOdLow, extCmp, d, m, r;
    int errors, testsRun;

    mmio_port mmio_port_inst (.ref_clk, .rst, .addr, .wdata, .wrStb, .rdStb, .rmwStb,
        .rdata, .extBusMode, .busOut, .busOe, .periStdOut, .periStdOe, .periOdOut,
        .cmpMatch, .stdPinIn, .stdPinOut, .stdPinOe, .odPinIn, .odPinOut, .odPinOe,
        .cmpPinIn, .cmpPinOut, .cmpPinOe);
    mmio_board mmio_board_inst (.stdOut(stdPinOut), .stdOe(stdPinOe), .odOe(odPinOe),
        .cmpOut(cmpPinOut), .cmpOe(cmpPinOe), .extStd, .extOdLow, .extCmp,
        .stdPin(stdPinIn), .odPin(odPinIn), .cmpPin(cmpPinIn));

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    // One-cycle write, returns once the pins have settled
    task automatic wr(input logic [7:0] a, input logic [7:0] dv, input logic rmw);
        @(posedge ref_clk);
        addr <= a;
        wdata <= dv;
        wrStb <= 1'h1;
        rmwStb <= rmw;
        @(posedge ref_clk);
        wrStb <= 1'h0;
        rmwStb <= 1'h0;
        @(posedge ref_clk);
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        addr <= a;
        rdStb <= 1'h1;
        @(posedge ref_clk);
        rdStb <= 1'h0;
        #1;
        q = rdata;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", testsRun, errors);
        if (errors == 0 && testsRun > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Bitwise select: a where s is 1, else b
    function automatic logic [7:0] mix(input logic [7:0] a, b, s);
        return (a & s) | (b & ~s);
    endfunction

    always #50 ref_clk = ~ref_clk;

    // Hang guard, well above the scripted run
    initial
    begin
        #2000000;
        errors++;
        summarize();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {ref_clk, wrStb, rdStb, rmwStb, extBusMode} = 5'h00;
        rst = 1'h1;
        {addr, wdata, busOut, busOe, periStdOut, periStdOe, periOdOut} = 56'h0;
        {cmpMatch, extStd, extOdLow, extCmp} = 32'h0;
        errors = 0;
        testsRun = 0;
        void'($urandom(32'h45FA7326));
        repeat (16) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        #1;
        chk(stdPinOe, 8'h00);
        chk(cmpPinOe, 8'h00);
        rd(mmio_pkg::OFF_DATA_OD, r);
        chk(r, 8'hFF);
        // Random data and direction, board drives released bits
        for (int i = 0; i < 8; i++)
        begin
            d = 8'($urandom);
            m = 8'($urandom);
            extStd <= 8'($urandom);
            wr(mmio_pkg::OFF_DATA_STD, d, 1'h0);
            wr(mmio_pkg::OFF_DIR_STD, m, 1'h0);
            chk(stdPinOe, m);
            chk(stdPinOut & m, d & m);
            rd(mmio_pkg::OFF_DATA_STD, r);
            chk(r, mix(d, extStd, m));
        end
        // Writes to input bits are held, then show once driven
        extStd <= 8'h3C;
        wr(mmio_pkg::OFF_DIR_STD, 8'h0F, 1'h0);
        wr(mmio_pkg::OFF_DATA_STD, 8'hA5, 1'h0);
        chk(stdPinOe, 8'h0F);
        rd(mmio_pkg::OFF_DATA_STD, r);
        chk(r, mix(8'hA5, 8'h3C, 8'h0F));
        wr(mmio_pkg::OFF_DIR_STD, 8'hFF, 1'h0);
        chk(stdPinOut, 8'hA5);
        // Read-modify-write pulls pin levels into input latches
        wr(mmio_pkg::OFF_DIR_STD, 8'h0F, 1'h0);
        wr(mmio_pkg::OFF_DATA_STD, 8'hC3, 1'h1);
        wr(mmio_pkg::OFF_DIR_STD, 8'hFF, 1'h0);
        chk(stdPinOut, mix(8'hC3, 8'h3C, 8'h0F));
        // Upper nibble handed to the peripheral
        periStdOut <= 8'h9A;
        periStdOe <= 8'hFF;
        wr(mmio_pkg::OFF_DIR_STD, 8'h00, 1'h0);
        wr(mmio_pkg::OFF_SEL_STD, 8'hFF, 1'h0);
        rd(mmio_pkg::OFF_SEL_STD, r);
        chk(r, 8'hF0);
        chk(stdPinOe, 8'hF0);
        chk(stdPinOut & 8'hF0, 8'h90);
        wr(mmio_pkg::OFF_SEL_STD, 8'h00, 1'h0);
        // External bus mode owns the pins unless selected back
        extBusMode <= 1'h1;
        busOut <= 8'h5A;
        busOe <= 8'hFF;
        wr(mmio_pkg::OFF_BUS_SEL, 8'h00, 1'h0);
        chk(stdPinOut, 8'h5A);
        chk(stdPinOe, 8'hFF);
        wr(mmio_pkg::OFF_BUS_SEL, 8'h0F, 1'h0);
        chk(stdPinOe, 8'hF0);
        chk(stdPinOut, mix(8'h5A, 8'h33, 8'hF0));
        rd(mmio_pkg::OFF_BUS_SEL, r);
        chk(r, 8'h0F);
        rd(mmio_pkg::OFF_STATUS, r);
        chk(r, 8'h01);
        extBusMode <= 1'h0;
        wr(mmio_pkg::OFF_BUS_SEL, 8'h00, 1'h0);
        chk(stdPinOe, 8'h00);
        // Open-drain: zeros sink, ones release to the pull-up
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($urandom);
            wr(mmio_pkg::OFF_DATA_OD, d, 1'h0);
            chk(odPinOe, ~d);
            chk(odPinOut, 8'h00);
            rd(mmio_pkg::OFF_DATA_OD, r);
            chk(r, d);
        end
        // Board sinks low nibble; modify-write keeps latch, read shows pin
        extOdLow <= 8'h0F;
        wr(mmio_pkg::OFF_DATA_OD, 8'hFF, 1'h1);
        chk(odPinOe, 8'h00);
        rd(mmio_pkg::OFF_DATA_OD, r);
        chk(r, 8'hF0);
        extOdLow <= 8'h00;
        periOdOut <= 8'h3C;
        wr(mmio_pkg::OFF_SEL_OD, 8'hFF, 1'h0);
        chk(odPinOe, 8'hC3);
        wr(mmio_pkg::OFF_SEL_OD, 8'h00, 1'h0);
        // Compare port: level waits for the match pulse
        wr(mmio_pkg::OFF_DIR_CMP, 8'hFF, 1'h0);
        wr(mmio_pkg::OFF_DATA_CMP, 8'hFF, 1'h0);
        chk(cmpPinOut, 8'h00);
        wr(mmio_pkg::OFF_CMP_LVL, 8'h5A, 1'h0);
        chk(cmpPinOut, 8'h00);
        rd(mmio_pkg::OFF_CMP_LVL, r);
        chk(r, 8'h5A);
        @(posedge ref_clk);
        cmpMatch <= 8'h0F;
        @(posedge ref_clk);
        cmpMatch <= 8'h00;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(cmpPinOut, 8'h0A);
        chk(cmpPinOe, 8'hFF);
        rd(mmio_pkg::OFF_DATA_CMP, r);
        chk(r, 8'h0A);
        extCmp <= 8'h66;
        wr(mmio_pkg::OFF_DIR_CMP, 8'h00, 1'h0);
        chk(cmpPinOe, 8'h00);
        rd(mmio_pkg::OFF_DATA_CMP, r);
        chk(r, 8'h66);
        wr(mmio_pkg::OFF_SEL_CMP, 8'hA5, 1'h0);
        rd(mmio_pkg::OFF_SEL_CMP, r);
        chk(r, 8'hA5);
        // Mid-run reset: drivers released, directions back to input
        wr(mmio_pkg::OFF_DIR_CMP, 8'hFF, 1'h0);
        wr(mmio_pkg::OFF_DIR_STD, 8'hFF, 1'h0);
        wr(mmio_pkg::OFF_DATA_OD, 8'h00, 1'h0);
        rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        #1;
        chk(cmpPinOe, 8'h00);
        chk(stdPinOe, 8'h00);
        chk(odPinOe, 8'h00);
        rd(mmio_pkg::OFF_DIR_STD, r);
        chk(r, 8'h00);
        // Unmapped place reads zero
        rd(8'h3F, r);
        chk(r, 8'h00);
        summarize();
    end
endmodule // test_multi_mode_io_port_logic
